// ==== verification/host_model.sv ====
// Host bus model: drives control pins, address and data lanes for one access at a time.
// Assumes the steering block samples its pins on ref_clk with a few cycles of sync delay.
`timescale 1ns/1ps
`default_nettype none

module host_model (
    input wire logic ref_clk,        // Bench clock
    input wire logic [15:0] adioOut, // Mux read data
    input wire logic [1:0] adioOe,   // Mux lane enables
    input wire logic [15:0] dataOut, // Non-mux read data
    input wire logic [1:0] dataOe,   // Non-mux lane enables
    output logic controlIn0,         // Control input 0
    output logic controlIn1,         // Control input 1
    output logic controlIn2,         // Control input 2
    output logic portDBitThree,      // High write strobe
    output logic addressStrobe,      // Address strobe
    output logic [15:0] adioIn,      // Address or address/data lines
    output logic [15:0] dataIn,      // Separate data lanes
    output logic [2:0] burstAddr,    // Unmultiplexed A3-A1
    output logic [3:0] extraAddr     // Upper address bits
);
    // ------------------------------------------------------------
    // Idle pins
    // ------------------------------------------------------------
    initial
    begin
        {controlIn0, controlIn1, controlIn2, portDBitThree} = 4'hF;
        addressStrobe = 1'b0;
        adioIn = 16'h0000;
        dataIn = 16'h0000;
        burstAddr = 3'h0;
        extraAddr = 4'h0;
    end

    // One access; kind 0 word, 1 even byte, 2 odd byte
    task automatic access(input int mode, input bit mux, input bit wr, input int kind, input logic [19:0] addr,
        input logic [7:0] ev, input logic [7:0] od, output logic [15:0] rd, output logic [1:0] oe,
        output logic [1:0] oeOff, input bit brst);
        logic [15:0] lanes;
        logic e;
        logic o;
        lanes = (mode == 2 || mode == 3) ? {ev, od} : {od, ev};
        e = (kind != 2);
        o = (kind != 1);
        @(posedge ref_clk);
        extraAddr <= addr[19:16];
        adioIn <= brst ? addr[19:4] : addr[15:0];
        burstAddr <= addr[3:1];
        addressStrobe <= mux;
        repeat (6) @(posedge ref_clk);
        addressStrobe <= 1'b0;
        repeat (6) @(posedge ref_clk);
        // Data phase; released lines show the inverse of their last value
        if (mux)
            adioIn <= wr ? lanes : ~addr[15:0];
        dataIn <= wr ? lanes : ~dataIn;
        controlIn0 <= (mode == 1 || mode == 4) ? !(wr && e) : !wr;
        controlIn1 <= (mode == 2) ? 1'b0 : (mode == 3) ? !e : wr;
        controlIn2 <= (mode == 2) ? (kind != 0) : (mode == 0 || mode == 3) ? !o : 1'b1;
        portDBitThree <= (mode == 1 || mode == 4) ? !(wr && o) : 1'b1;
        repeat (12) @(posedge ref_clk);
        rd = mux ? adioOut : dataOut;
        oe = mux ? adioOe : dataOe;
        // Strobes end first, address and data hold afterwards
        {controlIn0, controlIn1, controlIn2, portDBitThree} <= 4'hF;
        repeat (10) @(posedge ref_clk);
        oeOff = mux ? adioOe : dataOe;
    endtask

    // Code fetch inside a burst: only A3-A1 step, upper address stays latched
    task automatic fetch(input logic [2:0] a, output logic [15:0] rd, output logic [1:0] oe);
        @(posedge ref_clk);
        burstAddr <= a;
        controlIn2 <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rd = adioOut;
        oe = adioOe;
        controlIn2 <= 1'b1;
        repeat (8) @(posedge ref_clk);
    endtask
endmodule

`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench: byte-array model of the store compared with every read.
// Assumes the host model drives all pins and the bench owns the register port.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import mcu16_lane_pkg::*;

    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic controlIn0, controlIn1, controlIn2, portDBitThree, addressStrobe;
    logic [15:0] adioIn, adioOut, dataIn, dataOut, regRdata;
    logic [1:0] adioOe, dataOe;
    logic [2:0] burstAddr;
    logic [3:0] extraAddr;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] mem [0:511];
    logic [15:0] got;
    logic [7:0] w;
    logic brst = 1'b0;
    logic [1:0] fo;
    int failures = 0;
    int nCompared = 0;
    int nWr = 0;
    int nRd = 0;

    // ------------------------------------------------------------
    // Clock, design and host
    // ------------------------------------------------------------
    always #5 ref_clk = ~ref_clk;

    mcu16_byte_lane_steering #(.MEM_AW(8)) i_mcu16_byte_lane_steering (.ref_clk(ref_clk), .rst_b(rst_b),
        .controlIn0(controlIn0), .controlIn1(controlIn1), .controlIn2(controlIn2), .portDBitThree(portDBitThree),
        .addressStrobe(addressStrobe), .adioIn(adioIn), .adioOut(adioOut), .adioOe(adioOe), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe(dataOe), .burstAddr(burstAddr), .extraAddr(extraAddr), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));

    host_model i_host_model (.ref_clk(ref_clk), .adioOut(adioOut), .adioOe(adioOe), .dataOut(dataOut),
        .dataOe(dataOe), .controlIn0(controlIn0), .controlIn1(controlIn1), .controlIn2(controlIn2),
        .portDBitThree(portDBitThree), .addressStrobe(addressStrobe), .adioIn(adioIn), .dataIn(dataIn),
        .burstAddr(burstAddr), .extraAddr(extraAddr));

    // ------------------------------------------------------------
    // Checks and bus tasks
    // ------------------------------------------------------------
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] seen);
        nCompared++;
        if (exp !== seen)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", nCompared, failures);
        if (failures == 0 && nCompared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask

    task automatic regRead(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask

    // One host access, model update and comparison
    task automatic run(input int mode, input bit mux, input bit wr, input int kind, input logic [10:0] hi);
        logic [15:0] rd, mask, exp;
        logic [1:0] oe, oeOff, expOe;
        logic [7:0] ev, od;
        logic big;
        ev = 8'($urandom);
        od = 8'($urandom);
        big = (mode == 2 || mode == 3);
        i_host_model.access(mode, mux, wr, kind, {hi, w, kind == 2}, ev, od, rd, oe, oeOff, brst);
        nWr += int'(wr && hi == 11'h000);
        nRd += int'(!wr && hi == 11'h000);
        if (wr && hi == 11'h000)
        begin
            if (kind != 2)
                mem[{w, 1'b0}] = ev;
            if (kind != 1)
                mem[{w, 1'b1}] = od;
        end
        expOe = (kind == 0 || mode == 1 || mode == 4) ? 2'b11 : ((kind == 1) == big) ? 2'b10 : 2'b01;
        if (wr || hi != 11'h000)
            expOe = 2'b00;
        mask = {{8{expOe[1]}}, {8{expOe[0]}}};
        exp = big ? {mem[{w, 1'b0}], mem[{w, 1'b1}]} : {mem[{w, 1'b1}], mem[{w, 1'b0}]};
        cmp("lane enables", {14'h0, expOe}, {14'h0, oe});
        cmp("read data", mask & exp, mask & rd);
        cmp("released enables", 16'h0000, {14'h0, oeOff});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h3BFFBCCF));
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        regRead(REG_CONFIG, got);
        cmp("config reset", CONFIG_RESET, got);
        regRead(REG_BASE, got);
        cmp("base reset", BASE_RESET, got);
        regRead(4'hF, got);
        cmp("unmapped read", 16'h0000, got);
        for (int m = 0; m < 5; m++)
            for (int x = 0; x < 2; x++)
                if (x == 0 || m < 2)
                begin
                    regWrite(REG_CONFIG, 16'(m + 8 * x));
                    w = 8'($urandom);
                    run(m, x, 1, 0, 11'h000);
                    run(m, x, 0, 0, 11'h000);
                    run(m, x, 1, 2, 11'h000);
                    run(m, x, 1, 1, 11'h000);
                    run(m, x, 0, 1, 11'h000);
                    run(m, x, 0, 2, 11'h000);
                    run(m, x, 1, 0, 11'h080);
                    run(m, x, 0, 0, 11'h080);
                    run(m, x, 0, 0, 11'h000);
                    $display("test mode %0d mux %0d done", m, x);
                end
        // Burst: words written with the strobe, then fetched by stepping A3-A1 only
        regWrite(REG_CONFIG, 16'h0039);
        brst = 1'b1;
        w = 8'($urandom);
        for (int k = 0; k < 4; k++)
        begin
            w[2:0] = 3'(k);
            run(1, 1, 1, 0, 11'h000);
        end
        for (int k = 0; k < 4; k++)
        begin
            i_host_model.fetch(3'(k), got, fo);
            nRd++;
            cmp("fetch data", {mem[{w[7:3], 3'(k), 1'b1}], mem[{w[7:3], 3'(k), 1'b0}]}, got);
            cmp("fetch enables", 16'h0003, {14'h0, fo});
        end
        $display("test burst fetch done");
        regRead(REG_WRCOUNT, got);
        cmp("write count", 16'(nWr), got);
        regRead(REG_RDCOUNT, got);
        cmp("read count", 16'(nRd), got);
        wrap_up();
    end

    // Watchdog sized well past the expected run length
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        failures++;
        wrap_up();
    end
endmodule

`default_nettype wire

// ==== verilog/lane_word_mem.sv ====
// Small word store with one byte array per lane and a registered read port.
// Assumes writes and reads come from the same clock; no reset on the storage.
`timescale 1ns/1ps
`default_nettype none

module lane_word_mem #(
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk,                // System clock
    input wire logic writeEn,                // Write pulse
    input wire logic [1:0] byteEn,           // Bit 0 even byte, bit 1 odd byte
    input wire logic [ADDR_W-1:0] writeAddr, // Word index for writes
    input wire logic [15:0] writeData,       // Odd byte high, even byte low
    input wire logic [ADDR_W-1:0] readAddr,  // Word index for reads
    output logic [15:0] readData             // Registered read word
);

    genvar gl;
    // ----------------------------------------------------------------
    // One array per byte lane so each lane has a single writer
    // ----------------------------------------------------------------
    generate
        for (gl = 0; gl < 2; gl++)
        begin : g_lane
            logic [7:0] store [0:(1<<ADDR_W)-1];
            // Byte write and registered read
            always_ff @(posedge ref_clk)
            begin
                if (writeEn && byteEn[gl])
                    store[writeAddr] <= writeData[gl*8 +: 8];
                readData[gl*8 +: 8] <= store[readAddr];
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ==== verilog/mcu16_byte_lane_steering.sv ====
// Host-side byte-lane steering for a 16-bit microcontroller bus into an internal word store.
// Assumes host pins are asynchronous to ref_clk and a local register port on ref_clk.
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module mcu16_byte_lane_steering
    import mcu16_lane_pkg::*;
#(
    parameter int MEM_AW = 8
) (
    input wire logic ref_clk,            // 100 MHz clock
    input wire logic rst_b,              // Async reset, active low
    input wire logic controlIn0,         // Control input 0
    input wire logic controlIn1,         // Control input 1
    input wire logic controlIn2,         // Control input 2
    input wire logic portDBitThree,      // High write strobe pin
    input wire logic addressStrobe,      // Address strobe, active high
    input wire logic [15:0] adioIn,      // Address or multiplexed address/data in
    output logic [15:0] adioOut,         // Multiplexed read data out
    output logic [1:0] adioOe,           // Lane enables {upper, lower}
    input wire logic [15:0] dataIn,      // Separate data lanes in
    output logic [15:0] dataOut,         // Separate data lanes out
    output logic [1:0] dataOe,           // Lane enables {upper, lower}
    input wire logic [2:0] burstAddr,    // Unmultiplexed A3-A1
    input wire logic [3:0] extraAddr,    // Host address bits 19-16
    input wire logic [3:0] regAddr,      // Register address
    input wire logic [15:0] regWdata,    // Register write data
    input wire logic regWr,              // Register write strobe
    input wire logic regRd,              // Register read strobe
    output logic [15:0] regRdata         // Register read data, next cycle
);

    localparam int SEL_W = ADDR_WIDTH - MEM_AW - 1;

    logic [PIN_COUNT-1:0] pinRaw;
    logic [PIN_COUNT-1:0] pinF;
    logic c0, c1, c2, pd3, asF;
    logic [15:0] adioF, dataF;
    logic [2:0] burstF;
    logic [3:0] extraF;
    logic [15:0] cfg, base, wrCount, rdCount;
    bus_mode_e mode;
    logic muxMode, burstEn, fetchEn;
    logic [15:0] latchedAddr;
    logic [ADDR_WIDTH-1:0] curAddr;
    logic a0;
    logic rdActive, wrActive, upperLane, lowerLane, bigEndian;
    logic evenEn, oddEn, selected;
    logic [15:0] laneData, wordIn, memRdata, driveData;
    logic [MEM_AW-1:0] wrAddr;
    logic [1:0] wrBe;
    logic [15:0] wrData;
    logic wrPending, memWe;
    logic rdSelQ, rdPrev;
    logic [1:0] lanesQ;

    // ----------------------------------------------------------------
    // Pin synchronisers: three stages, update once stages two and three agree
    // ----------------------------------------------------------------
    assign pinRaw = {extraAddr, burstAddr, dataIn, adioIn, addressStrobe, portDBitThree,
                     controlIn2, controlIn1, controlIn0};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++)
        begin : g_sync
            logic [SYNC_STAGES-1:0] chain;
            logic filt;
            // Shift chain and agreement filter
            always_ff @(posedge ref_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    chain <= {SYNC_STAGES{PIN_IDLE[gi]}};
                    filt <= PIN_IDLE[gi];
                end
                else
                begin
                    chain <= {chain[SYNC_STAGES-2:0], pinRaw[gi]};
                    if (chain[1] == chain[2])
                        filt <= chain[2];
                end
            end
            assign pinF[gi] = filt;
        end
    endgenerate

    // Filtered pin fields
    assign c0 = pinF[PIN_C0];
    assign c1 = pinF[PIN_C1];
    assign c2 = pinF[PIN_C2];
    assign pd3 = pinF[PIN_PD3];
    assign asF = pinF[PIN_AS];
    assign adioF = pinF[PIN_MUX_ADDR_DATA_PORT_LSB +: HOST_ADDR_BITS];
    assign dataF = pinF[PIN_DATA_LSB +: 16];
    assign burstF = pinF[PIN_BURST_LSB +: BURST_ADDR_BITS];
    assign extraF = pinF[PIN_EXTRA_LSB +: EXTRA_ADDR_BITS];

    // ----------------------------------------------------------------
    // Configuration fields
    // ----------------------------------------------------------------
    assign mode = bus_mode_e'(cfg[CFG_MODE_LSB +: 3]);
    assign muxMode = cfg[CFG_MUX_BIT];
    assign burstEn = cfg[CFG_BURST_BIT];
    assign fetchEn = cfg[CFG_FETCH_BIT];

    // ----------------------------------------------------------------
    // Address path
    // ----------------------------------------------------------------
    // Latch multiplexed address while the strobe is high
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            latchedAddr <= 16'h0000;
        else if (muxMode && asF)
            latchedAddr <= adioF;
    end

    // Build the full access address for the current bus style
    always_comb
    begin
        if (muxMode && burstEn)
            curAddr = {latchedAddr, burstF, 1'b0};
        else if (muxMode)
            curAddr = {extraF, latchedAddr};
        else
            curAddr = {extraF, adioF};
    end

    assign a0 = curAddr[0];
    assign selected = (curAddr[ADDR_WIDTH-1:MEM_AW+1] == base[SEL_W-1:0]);

    // ----------------------------------------------------------------
    // Control-pin decode per host style
    // ----------------------------------------------------------------
    always_comb
    begin
        rdActive = 1'b0;
        wrActive = 1'b0;
        upperLane = 1'b0;
        lowerLane = 1'b0;
        bigEndian = 1'b0;
        case (mode)
            MODE_BHE:
            begin
                wrActive = !c0;
                rdActive = !c1;
                upperLane = !c2;
                lowerLane = !a0;
            end
            MODE_WRHL, MODE_OEWR:
            begin
                rdActive = !c1 || (mode == MODE_WRHL && fetchEn && !c2);
                wrActive = !c0 || !pd3;
                upperLane = rdActive ? 1'b1 : !pd3;
                lowerLane = rdActive ? 1'b1 : !c0;
            end
            MODE_SIZE:
            begin
                rdActive = !c1 && c0;
                wrActive = !c1 && !c0;
                upperLane = !a0;
                lowerLane = !c2 || a0;
                bigEndian = 1'b1;
            end
            MODE_UDS:
            begin
                rdActive = (!c1 || !c2) && c0;
                wrActive = (!c1 || !c2) && !c0;
                upperLane = !c1;
                lowerLane = !c2;
                bigEndian = 1'b1;
            end
            default:
            begin
                rdActive = 1'b0;
            end
        endcase
    end

    // Map lanes onto even and odd bytes
    assign evenEn = bigEndian ? upperLane : lowerLane;
    assign oddEn = bigEndian ? lowerLane : upperLane;

    // ----------------------------------------------------------------
    // Write path: capture during the strobe, commit when it ends
    // ----------------------------------------------------------------
    assign laneData = muxMode ? adioF : dataF;
    assign wordIn = bigEndian ? {laneData[7:0], laneData[15:8]} : laneData;
    assign memWe = wrPending && !wrActive;

    // Hold address, lanes and data of the last active write cycle
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wrPending <= 1'b0;
            wrAddr <= '0;
            wrBe <= 2'h0;
            wrData <= 16'h0000;
        end
        else if (wrActive && selected)
        begin
            wrPending <= 1'b1;
            wrAddr <= curAddr[MEM_AW:1];
            wrBe <= {oddEn, evenEn};
            wrData <= wordIn;
        end
        else if (memWe)
            wrPending <= 1'b0;
    end

    lane_word_mem #(
        .ADDR_W(MEM_AW)
    ) u_mem (
        .ref_clk(ref_clk),
        .writeEn(memWe),
        .byteEn(wrBe),
        .writeAddr(wrAddr),
        .writeData(wrData),
        .readAddr(curAddr[MEM_AW:1]),
        .readData(memRdata)
    );

    // ----------------------------------------------------------------
    // Read path: lanes driven two cycles after decode, in step with data
    // ----------------------------------------------------------------
    assign driveData = bigEndian ? {memRdata[7:0], memRdata[15:8]} : memRdata;

    // Delay decode one stage to match the store's read latency
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdSelQ <= 1'b0;
            lanesQ <= 2'h0;
            rdPrev <= 1'b0;
        end
        else
        begin
            rdSelQ <= rdActive && selected;
            lanesQ <= {upperLane, lowerLane};
            rdPrev <= rdActive && selected;
        end
    end

    // Output lanes and their enables
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            adioOut <= 16'h0000;
            dataOut <= 16'h0000;
            adioOe <= 2'h0;
            dataOe <= 2'h0;
        end
        else
        begin
            adioOut <= driveData;
            dataOut <= driveData;
            adioOe <= (rdSelQ && muxMode) ? lanesQ : 2'h0;
            dataOe <= (rdSelQ && !muxMode) ? lanesQ : 2'h0;
        end
    end

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    // Writable configuration
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg <= CONFIG_RESET;
            base <= BASE_RESET;
        end
        else if (regWr && regAddr == REG_CONFIG)
            cfg <= regWdata;
        else if (regWr && regAddr == REG_BASE)
            base <= regWdata;
    end

    // Access counters
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wrCount <= COUNT_RESET;
            rdCount <= COUNT_RESET;
        end
        else
        begin
            if (memWe)
                wrCount <= wrCount + 16'h0001;
            if (rdActive && selected && !rdPrev)
                rdCount <= rdCount + 16'h0001;
        end
    end

    // Read data stands for one cycle only; unmapped reads return zero
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            regRdata <= 16'h0000;
        else if (regRd)
        begin
            case (regAddr)
                REG_CONFIG: regRdata <= cfg;
                REG_BASE: regRdata <= base;
                REG_STATUS: regRdata <= {11'h000, oddEn, evenEn, selected, wrActive, rdActive};
                REG_WRCOUNT: regRdata <= wrCount;
                REG_RDCOUNT: regRdata <= rdCount;
                default: regRdata <= 16'h0000;
            endcase
        end
        else
            regRdata <= 16'h0000;
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    a_drive_needs_read: assert property ((|{adioOe, dataOe}) |-> $past(rdActive && selected, 2))
        else $error("data lanes driven without a selected read");
    a_release_idle: assert property (!(rdActive && selected) ##1 !(rdActive && selected)
        |=> ({adioOe, dataOe} == 4'h0))
        else $error("data lanes not released after read ended");
    a_lane_follow: assert property ((rdActive && selected && muxMode) ##1 muxMode
        |=> (adioOe == $past({upperLane, lowerLane}, 2)))
        else $error("driven lanes differ from selected lanes");
    a_bhe_odd: assert property ((mode == MODE_BHE && !c2 && a0) |-> (oddEn && !evenEn))
        else $error("high-enable odd access mis-steered");
    a_wrh_only: assert property ((mode == MODE_WRHL && c1 && !c2 && c0 && !pd3)
        |-> (oddEn && !evenEn))
        else $error("high write strobe did not pick odd byte only");
    a_size_even: assert property ((mode == MODE_SIZE && c2 && !a0) |-> (evenEn && !oddEn && bigEndian))
        else $error("size-bit even byte not on upper lane alone");
    a_uds_word: assert property ((mode == MODE_UDS && !c1 && !c2) |-> (evenEn && oddEn && bigEndian))
        else $error("both data strobes did not select a word");
    a_write_commit: assert property (memWe |-> ($past(wrActive) && !wrActive) ##1 !memWe)
        else $error("write committed at the wrong moment");
    a_addr_latch: assert property ((muxMode && asF) |=> (latchedAddr == $past(adioF)))
        else $error("multiplexed address not latched");
    a_burst_addr: assert property ((muxMode && burstEn && !asF) |=> $stable(latchedAddr))
        else $error("burst upper address moved without address strobe");

    c_word_write: cover property (memWe && wrBe == 2'h3);
    c_burst_read: cover property (muxMode && burstEn && rdActive && selected ##2 (adioOe == 2'h3));
    c_byte_read: cover property (!muxMode && dataOe == 2'h2);
    c_size_write: cover property (mode == MODE_SIZE && memWe && wrBe == 2'h2);

endmodule
`default_nettype wire

// ==== verilog/mcu16_lane_pkg.sv ====
// Constants, field layouts and mode codes for the 16-bit host byte-lane steering block.
// Assumes a single 100 MHz clock domain and host pins that arrive asynchronously.
//
// Contract
// - Address bit 0 low is the even byte, high is the odd byte.
// - High-enable mode: word, odd byte on upper lane, or even byte on lower lane.
// - Separate low and high write strobes select lower, upper or both lanes.
// - Size-bit mode is big-endian: word, even byte upper, or odd byte lower.
// - Upper/lower data strobes, big-endian: each active strobe selects its own lane.
// - Without high-enable, low write on control input 0, high write on port D bit three.
// - Host address bits above 16 enter on extra ports and join the decode.
// - Non-multiplexed size-bit host uses control inputs 0-2 for read/write, strobe, size.
// - Burst host: A3-A1 arrive separately, A19-A4 share the data lines.
// - During a burst A19-A4 stay latched while A3-A1 step through code words.
// - Output-enable read strobe with separate low and high write strobes is supported.
// - Multiplexed hosts may use write/read/high-enable or read/low write/high write.
// - The multiplexed address is latched internally by the address strobe.
// - Data lines are driven only while selected and read is active, else released.

package mcu16_lane_pkg;

    // ----------------------------------------------------------------
    // Pin sampling
    // ----------------------------------------------------------------
    localparam int SYNC_STAGES = 3;
    localparam int PIN_COUNT = 44;
    localparam int PIN_C0 = 0;
    localparam int PIN_C1 = 1;
    localparam int PIN_C2 = 2;
    localparam int PIN_PD3 = 3;
    localparam int PIN_AS = 4;
    localparam int PIN_MUX_ADDR_DATA_PORT_LSB = 5;
    localparam int PIN_DATA_LSB = 21;
    localparam int PIN_BURST_LSB = 37;
    localparam int PIN_EXTRA_LSB = 40;
    // Strobes idle high, address strobe idle low
    localparam logic [43:0] PIN_IDLE = 44'h0000000000F;

    // ----------------------------------------------------------------
    // Address layout
    // ----------------------------------------------------------------
    localparam int ADDR_WIDTH = 20;
    localparam int HOST_ADDR_BITS = 16;
    localparam int BURST_ADDR_BITS = 3;
    localparam int EXTRA_ADDR_BITS = 4;

    // ----------------------------------------------------------------
    // Register port map
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_CONFIG = 4'h0;
    localparam logic [3:0] REG_BASE = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_WRCOUNT = 4'h3;
    localparam logic [3:0] REG_RDCOUNT = 4'h4;
    localparam logic [15:0] CONFIG_RESET = 16'h0008;
    localparam logic [15:0] BASE_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_MUX_BIT = 3;
    localparam int CFG_BURST_BIT = 4;
    localparam int CFG_FETCH_BIT = 5;

    // ----------------------------------------------------------------
    // Host control-pin assignments
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {MODE_BHE, MODE_WRHL, MODE_SIZE, MODE_UDS, MODE_OEWR} bus_mode_e;

endpackage
